/* dv/nvsc_chk.sv */
// Purpose: Pin and bus checks for the store/recall host controller.
// Assumes: Bound to nvsc_ctrl; one clock domain.
// Notes: Access lengths follow the hand-over figures.
`timescale 1ns/1ps
module nvsc_chk (
	input wire logic ref_clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic s_axi_awvalid, // Write address valid
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic chip_sel_n, // Chip select
	input wire logic write_en_n, // Write enable
	input wire logic out_en_n, // Output enable
	input wire logic [14:0] sram_addr, // Address pins
	input wire logic data_io_oe, // Data driven
	input wire logic store_busy_n_i, // Store/busy level
	input wire logic store_busy_n_oe // Store/busy pulled
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Access shapes
	// ------------------------------------------------------------
	sequence s_low_pair;
		!chip_sel_n [*2] ##1 chip_sel_n;
	endsequence
	sequence s_quiet;
		(!store_busy_n_oe && chip_sel_n) [*8];
	endsequence
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_cs_window: assert property ($fell(chip_sel_n) |-> s_low_pair)
		else $error("chip select low phase has the wrong length");
	a_addr_stable: assert property (!chip_sel_n && !$fell(chip_sel_n) |-> $stable(sram_addr))
		else $error("address moved while selected");
	a_pull_pulse: assert property ($rose(store_busy_n_oe) |-> chip_sel_n ##1 s_quiet)
		else $error("store pull not a clean single pulse");
	a_start_pin: assert property ($fell(chip_sel_n) |-> store_busy_n_i)
		else $error("access started while store pin low");
	a_recover: assert property ($rose(store_busy_n_i) |-> chip_sel_n [*8])
		else $error("access too soon after store pin rose");
	a_we_with_cs: assert property ($fell(write_en_n) |-> $fell(chip_sel_n))
		else $error("write enable fell without chip select");
	a_data_drive: assert property (data_io_oe |-> !write_en_n && !chip_sel_n)
		else $error("data driven outside a write");
	a_read_oe: assert property (!out_en_n |-> !chip_sel_n && write_en_n)
		else $error("output enable low outside a read");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
endmodule
bind nvsc_ctrl nvsc_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.chip_sel_n(chip_sel_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
	.sram_addr(sram_addr), .data_io_oe(data_io_oe), .store_busy_n_i(store_busy_n_i),
	.store_busy_n_oe(store_busy_n_oe));

/* dv/nvsc_dev_model.sv */
// Purpose: Behavioural store/recall static RAM on the controller's pins.
// Assumes: Pins change on ref_clk edges; pull-up resolved in the bench.
// Notes: Nonvolatile cycles shortened to HOLD cycles.
`timescale 1ns/1ps
module nvsc_dev_model #(
	parameter int HOLD = 40 // Nonvolatile cycle length, cycles
) (
	input wire logic ref_clk, // Timing clock
	input wire logic chip_sel_n, // Chip select
	input wire logic write_en_n, // Write enable
	input wire logic out_en_n, // Output enable
	input wire logic [14:0] sram_addr, // Address pins
	input wire logic [7:0] data_io_o, // Host data
	input wire logic data_io_oe, // Host drives data
	input wire logic store_busy_n, // Resolved store/busy wire
	output logic dev_pull, // Device pulls store/busy
	output logic [7:0] data_io_i, // Resolved data wire
	output int store_cnt, // Stores done
	output int recall_cnt // Recalls done
);
	logic [7:0] mem [0:32767];
	logic [7:0] last = 8'h00;
	logic [13:0] seq [0:4];
	logic cs_q = 1'b1;
	logic dirty = 1'b0;
	logic hw_act = 1'b0;
	int step = 0;
	int nv_cnt = 8;
	int pull_cnt = 0;
	wire inhibit = hw_act || nv_cnt != 0;
	wire rd = !chip_sel_n && !out_en_n && write_en_n && store_busy_n && !inhibit;
	wire [13:0] a14 = sram_addr[13:0];
	initial begin
		dev_pull = 1'b0;
		store_cnt = 0;
		recall_cnt = 0;
		seq = '{nvsc_pkg::SEQ_A0, nvsc_pkg::SEQ_A1, nvsc_pkg::SEQ_A2, nvsc_pkg::SEQ_A3,
			nvsc_pkg::SEQ_A4};
	end
	// Undriven data shows the inverse of the last level
	assign data_io_i = rd ? mem[sram_addr] : (data_io_oe ? data_io_o : ~last);
	// Array, store pin and sequence detector
	always @(posedge ref_clk) begin
		cs_q <= chip_sel_n;
		last <= data_io_i;
		if (nv_cnt != 0)
			nv_cnt <= nv_cnt - 1;
		if (!chip_sel_n && !write_en_n && store_busy_n && !inhibit) begin
			mem[sram_addr] <= data_io_o;
			dirty <= 1'b1;
		end
		if (!store_busy_n && !hw_act) begin
			hw_act <= 1'b1;
			if (dirty) begin
				dev_pull <= 1'b1;
				pull_cnt <= HOLD;
				store_cnt <= store_cnt + 1;
				dirty <= 1'b0;
			end
		end else if (pull_cnt > 1)
			pull_cnt <= pull_cnt - 1;
		else if (pull_cnt == 1) begin
			dev_pull <= 1'b0;
			pull_cnt <= 0;
		end else if (hw_act && store_busy_n)
			hw_act <= 1'b0;
		// Stepped on each select fall, output enable unused
		if (cs_q && !chip_sel_n) begin
			if (!write_en_n || inhibit)
				step <= 0;
			else if (step == 5 && a14 == nvsc_pkg::SEQ_STORE) begin
				step <= 0;
				dirty <= 1'b0;
				nv_cnt <= HOLD;
				store_cnt <= store_cnt + 1;
			end else if (step == 5 && a14 == nvsc_pkg::SEQ_RECALL) begin
				step <= 0;
				dirty <= 1'b0;
				nv_cnt <= HOLD;
				recall_cnt <= recall_cnt + 1;
			end else if (step < 5 && a14 == seq[step])
				step <= step + 1;
			else
				step <= (a14 == seq[0]) ? 1 : 0;
		end
	end
endmodule

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the store/recall host controller.
// Assumes: Device model on the pins; AXI4-Lite master tasks.
// Notes: STORE_CYC shortened to 50 cycles.
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, chip_sel_n, write_en_n, out_en_n, data_io_oe, dev_pull;
	logic store_busy_n_o, store_busy_n_oe;
	logic [7:0] s_axi_awaddr, s_axi_araddr, data_io_i, data_io_o;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [14:0] sram_addr;
	int bad_count = 0;
	int comparisons = 0;
	int store_cnt, recall_cnt, s0;
	wire store_busy_n_i;
	// Pull-up wins unless a party pulls low
	assign store_busy_n_i = (store_busy_n_oe ? store_busy_n_o : 1'b1) && !dev_pull;
	nvsc_ctrl #(.STORE_CYC(50)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .chip_sel_n(chip_sel_n),
		.write_en_n(write_en_n), .out_en_n(out_en_n), .sram_addr(sram_addr),
		.data_io_i(data_io_i), .data_io_o(data_io_o), .data_io_oe(data_io_oe),
		.store_busy_n_i(store_busy_n_i), .store_busy_n_o(store_busy_n_o),
		.store_busy_n_oe(store_busy_n_oe));
	nvsc_dev_model u_dev (.ref_clk(ref_clk), .chip_sel_n(chip_sel_n), .write_en_n(write_en_n),
		.out_en_n(out_en_n), .sram_addr(sram_addr), .data_io_o(data_io_o),
		.data_io_oe(data_io_oe), .store_busy_n(store_busy_n_i), .dev_pull(dev_pull),
		.data_io_i(data_io_i), .store_cnt(store_cnt), .recall_cnt(recall_cnt));
	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw = 1'b1;
		logic w = 1'b1;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge ref_clk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	// One controller command, polled to done, done cleared
	task automatic cmd(input logic [2:0] c, input logic [14:0] a, input logic [7:0] d);
		int n = 0;
		axi_wr(nvsc_pkg::REG_ADDR, {17'h0, a});
		axi_wr(nvsc_pkg::REG_WDATA, {24'h0, d});
		axi_wr(nvsc_pkg::REG_CTRL, {28'h0, c, 1'b1});
		chk({30'h0, resp}, {30'h0, nvsc_pkg::RESP_OKAY});
		do begin
			axi_rd(nvsc_pkg::REG_STATUS);
			n++;
		end while (rd[1] !== 1'b1 && n < 3000);
		chk({30'h0, rd[1:0]}, 32'h2);
		axi_wr(nvsc_pkg::REG_STATUS, 32'h2);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		axi_rd(nvsc_pkg::REG_STATUS);
		chk(rd, 32'h4);
		axi_rd(8'h20);
		chk({30'h0, resp}, {30'h0, nvsc_pkg::RESP_SLVERR});
		chk(rd, 32'h0);
		axi_wr(8'h24, 32'h0);
		chk({30'h0, resp}, {30'h0, nvsc_pkg::RESP_SLVERR});
	endtask
	task automatic t_sw_store;
		s0 = store_cnt;
		cmd(nvsc_pkg::CMD_SSTORE, 15'h0, 8'h0);
		chk(store_cnt, s0 + 1);
		chk(recall_cnt, 0);
	endtask
	task automatic t_hw_store(input int inc);
		s0 = store_cnt;
		cmd(nvsc_pkg::CMD_HSTORE, 15'h0, 8'h0);
		chk(store_cnt, s0 + inc);
	endtask
	task automatic t_rw(input logic [14:0] a, input logic [7:0] d);
		cmd(nvsc_pkg::CMD_WRITE, a, d);
		cmd(nvsc_pkg::CMD_READ, a, 8'h0);
		axi_rd(nvsc_pkg::REG_RDATA);
		chk(rd, {24'h0, d});
	endtask
	task automatic t_recall;
		s0 = store_cnt;
		cmd(nvsc_pkg::CMD_SRECALL, 15'h0, 8'h0);
		chk(recall_cnt, 1);
		chk(store_cnt, s0);
		t_rw(15'h7FFF, 8'h3C);
	endtask
	task automatic results;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Clock and watchdog
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		bad_count++;
		results();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_sw_store();
		t_hw_store(0);
		t_rw(15'h1234, 8'hA5);
		t_hw_store(1);
		t_rw(15'h1234, 8'h5A);
		t_recall();
		results();
	end
endmodule

/* inc/nvsc_pkg.sv */
//
// Purpose: Constants for the host controller of a store/recall static RAM.
// Assumes: 40 MHz ref_clk; AXI4-Lite register access from software.
// Notes: Register map and command codes are the host's own.
package nvsc_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 25;
	localparam int T_ACC_NS = 35;
	localparam int T_GAP_NS = 25;
	localparam int T_PULSE_NS = 15;
	localparam int T_BUSY_NS = 300;
	localparam int T_RECOVER_NS = 700;
	localparam int T_RECALL_US = 20;
	localparam int T_STORE_MS = 10;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECALL_CYC = (T_RECALL_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int STORE_CYC = (T_STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 24;
	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int SEQ_LEN = 6;
	localparam logic [13:0] SEQ_A0 = 14'h0E38;
	localparam logic [13:0] SEQ_A1 = 14'h31C7;
	localparam logic [13:0] SEQ_A2 = 14'h03E0;
	localparam logic [13:0] SEQ_A3 = 14'h3C1F;
	localparam logic [13:0] SEQ_A4 = 14'h303F;
	localparam logic [13:0] SEQ_STORE = 14'h0FC0;
	localparam logic [13:0] SEQ_RECALL = 14'h0C63;
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	localparam int AXI_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int CTRL_GO = 0;
	localparam int CTRL_CMD_LSB = 1;
	localparam int CMD_W = 3;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_PIN = 2;
	localparam logic [2:0] CMD_READ = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h1;
	localparam logic [2:0] CMD_HSTORE = 3'h2;
	localparam logic [2:0] CMD_SSTORE = 3'h3;
	localparam logic [2:0] CMD_SRECALL = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* logic/nvsc_axil.sv */
//
// Purpose: AXI4-Lite slave front end for the controller registers.
// Assumes: One write and one read under way at most.
// Notes: Write address and data taken in either order.
//
`timescale 1ns/1ps
module nvsc_axil (
	input wire logic ref_clk, // Clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic reg_wr, // Register write pulse
	output logic [7:0] reg_waddr, // Register write address
	output logic [31:0] reg_wdata, // Register write data
	output logic [3:0] reg_wstrb, // Register write strobes
	input wire logic reg_wok, // Write address is mapped
	output logic [7:0] reg_raddr, // Register read address
	input wire logic [31:0] reg_rdata, // Register read value
	input wire logic reg_rok // Read address is mapped
);
	logic aw_got;
	logic w_got;

	// Handshake readies, closed while a response waits
	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready = !w_got && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign reg_wr = aw_got && w_got;
	assign reg_raddr = s_axi_araddr;

	// Capture address and data independently
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			reg_waddr <= 8'h00;
			reg_wdata <= 32'h0000_0000;
			reg_wstrb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				reg_waddr <= s_axi_awaddr;
			end else if (reg_wr) begin
				aw_got <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				reg_wdata <= s_axi_wdata;
				reg_wstrb <= s_axi_wstrb;
			end else if (reg_wr) begin
				w_got <= 1'b0;
			end
		end
	end

	// Write response after both halves arrive
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= nvsc_pkg::RESP_OKAY;
		end else if (reg_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= reg_wok ? nvsc_pkg::RESP_OKAY : nvsc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= nvsc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= reg_rdata;
			s_axi_rresp <= reg_rok ? nvsc_pkg::RESP_OKAY : nvsc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

/* logic/nvsc_ctrl.sv */
//
// Purpose: Host controller driving a store/recall static RAM over its pins.
// Assumes: Pin inputs synchronous to ref_clk; pull-up on the store/busy wire.
// Notes: Software issues one command at a time through the control register.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module nvsc_ctrl #(
	parameter int STORE_CYC = nvsc_pkg::STORE_CYC // Software store wait, cycles
) (
	input wire logic ref_clk, // 40 MHz clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	output logic chip_sel_n, // Chip select, active low
	output logic write_en_n, // Write enable, active low
	output logic out_en_n, // Output enable, active low
	output logic [14:0] sram_addr, // Address pins
	input wire logic [7:0] data_io_i, // Data pins, input side
	output logic [7:0] data_io_o, // Data pins, output side
	output logic data_io_oe, // Data pins driven
	input wire logic store_busy_n_i, // Store/busy pin level
	output logic store_busy_n_o, // Store/busy pull value, always low
	output logic store_busy_n_oe // Store/busy pulled low
);
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ACC = 7'h02,
		ST_GAP = 7'h04,
		ST_PULSE = 7'h08,
		ST_BWAIT = 7'h10,
		ST_RECOV = 7'h20,
		ST_NVWAIT = 7'h40
	} nvsc_state_e;

	nvsc_state_e state;
	logic [2:0] cmd;
	logic pend;
	logic done;
	logic [2:0] seq_idx;
	logic [nvsc_pkg::CNT_W-1:0] cnt;
	logic [14:0] addr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] rdata_reg;
	logic reg_wr;
	logic [7:0] reg_waddr;
	logic [31:0] reg_wdata;
	logic [3:0] reg_wstrb;
	logic [7:0] reg_raddr;
	logic [31:0] reg_rdata;
	logic reg_rok;
	logic reg_wok;
	logic is_seq;
	logic seq_last;
	logic start_ok;
	logic cnt_end;

	// Sequence address for a step; top address bit left low
	function automatic logic [14:0] seq_addr(input logic [2:0] idx, input logic recall);
		logic [13:0] a;
		a = nvsc_pkg::SEQ_A0;
		case (idx)
			3'h1: a = nvsc_pkg::SEQ_A1;
			3'h2: a = nvsc_pkg::SEQ_A2;
			3'h3: a = nvsc_pkg::SEQ_A3;
			3'h4: a = nvsc_pkg::SEQ_A4;
			3'h5: a = recall ? nvsc_pkg::SEQ_RECALL : nvsc_pkg::SEQ_STORE;
			default: a = nvsc_pkg::SEQ_A0;
		endcase
		return {1'b0, a};
	endfunction

	// Decoder for mapped register offsets
	function automatic logic reg_mapped(input logic [7:0] a);
		return a == nvsc_pkg::REG_CTRL || a == nvsc_pkg::REG_ADDR ||
			a == nvsc_pkg::REG_WDATA || a == nvsc_pkg::REG_STATUS ||
			a == nvsc_pkg::REG_RDATA;
	endfunction

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	nvsc_axil u_axil (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.reg_wr(reg_wr),
		.reg_waddr(reg_waddr),
		.reg_wdata(reg_wdata),
		.reg_wstrb(reg_wstrb),
		.reg_wok(reg_wok),
		.reg_raddr(reg_raddr),
		.reg_rdata(reg_rdata),
		.reg_rok(reg_rok)
	);

	assign reg_wok = reg_mapped(reg_waddr);
	assign reg_rok = reg_mapped(reg_raddr);
	assign is_seq = cmd == nvsc_pkg::CMD_SSTORE || cmd == nvsc_pkg::CMD_SRECALL;
	assign seq_last = seq_idx == 3'(nvsc_pkg::SEQ_LEN - 1);
	assign cnt_end = cnt == '0;
	// Accesses wait while the device holds store/busy low
	assign start_ok = pend && store_busy_n_i;

	// Register read mux
	always_comb begin
		reg_rdata = 32'h0000_0000;
		case (reg_raddr)
			nvsc_pkg::REG_CTRL: reg_rdata = {28'h0, cmd, 1'b0};
			nvsc_pkg::REG_ADDR: reg_rdata = {17'h0, addr_reg};
			nvsc_pkg::REG_WDATA: reg_rdata = {24'h0, wdata_reg};
			nvsc_pkg::REG_STATUS: reg_rdata = {29'h0, store_busy_n_i, done, pend};
			nvsc_pkg::REG_RDATA: reg_rdata = {24'h0, rdata_reg};
			default: reg_rdata = 32'h0000_0000;
		endcase
	end

	// Software-written settings; commands ignored while busy
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			addr_reg <= 15'h0000;
			wdata_reg <= 8'h00;
			cmd <= nvsc_pkg::CMD_READ;
		end else if (reg_wr && !pend && reg_wstrb[0]) begin
			if (reg_waddr == nvsc_pkg::REG_ADDR) begin
				addr_reg <= reg_wdata[14:0];
			end
			if (reg_waddr == nvsc_pkg::REG_WDATA) begin
				wdata_reg <= reg_wdata[7:0];
			end
			if (reg_waddr == nvsc_pkg::REG_CTRL && reg_wdata[nvsc_pkg::CTRL_GO]) begin
				cmd <= reg_wdata[nvsc_pkg::CTRL_CMD_LSB +: nvsc_pkg::CMD_W];
			end
		end
	end

	// Busy flag and sticky done flag; a new done wins over a clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pend <= 1'b0;
			done <= 1'b0;
		end else begin
			if (reg_wr && !pend && reg_wstrb[0] && reg_waddr == nvsc_pkg::REG_CTRL &&
				reg_wdata[nvsc_pkg::CTRL_GO]) begin
				pend <= 1'b1;
			end else if (state != ST_IDLE && state != ST_ACC && state != ST_GAP
				&& state != ST_PULSE && cnt_end && (state == ST_NVWAIT
				|| state == ST_RECOV)) begin
				pend <= 1'b0;
			end else if (state == ST_GAP && cnt_end && !is_seq) begin
				pend <= 1'b0;
			end
			if ((state == ST_GAP && cnt_end && !is_seq) ||
				((state == ST_NVWAIT || state == ST_RECOV) && cnt_end)) begin
				done <= 1'b1;
			end else if (reg_wr && reg_waddr == nvsc_pkg::REG_STATUS &&
				reg_wdata[nvsc_pkg::ST_DONE]) begin
				done <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin sequencer
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			cnt <= '0;
			seq_idx <= 3'h0;
			chip_sel_n <= 1'b1;
			write_en_n <= 1'b1;
			out_en_n <= 1'b1;
			sram_addr <= 15'h0000;
			data_io_o <= 8'h00;
			data_io_oe <= 1'b0;
			store_busy_n_oe <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			case (state)
				ST_IDLE: begin
					seq_idx <= 3'h0;
					if (start_ok && cmd == nvsc_pkg::CMD_HSTORE) begin
						store_busy_n_oe <= 1'b1;
						cnt <= nvsc_pkg::CNT_W'(nvsc_pkg::PULSE_CYC - 1);
						state <= ST_PULSE;
					end else if (start_ok) begin
						// Select falls with write enable on a write, with output enable on a read, alone otherwise
						chip_sel_n <= 1'b0;
						write_en_n <= cmd != nvsc_pkg::CMD_WRITE;
						out_en_n <= cmd != nvsc_pkg::CMD_READ;
						data_io_oe <= cmd == nvsc_pkg::CMD_WRITE;
						data_io_o <= wdata_reg;
						sram_addr <= is_seq ? seq_addr(3'h0, 1'b0) : addr_reg;
						cnt <= nvsc_pkg::CNT_W'(nvsc_pkg::ACC_CYC - 1);
						state <= ST_ACC;
					end
				end
				ST_ACC: begin
					// Store/busy is never pulled during an access
					store_busy_n_oe <= 1'b0;
					if (cnt_end) begin
						if (cmd == nvsc_pkg::CMD_READ) begin
							rdata_reg <= data_io_i;
						end
						chip_sel_n <= 1'b1;
						write_en_n <= 1'b1;
						out_en_n <= 1'b1;
						data_io_oe <= 1'b0;
						cnt <= nvsc_pkg::CNT_W'(nvsc_pkg::GAP_CYC - 1);
						state <= ST_GAP;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				ST_GAP: begin
					if (!cnt_end) begin
						cnt <= cnt - 1'b1;
					end else if (is_seq && seq_last) begin
						// Store runs with or without earlier writes
						cnt <= cmd == nvsc_pkg::CMD_SRECALL ?
							nvsc_pkg::CNT_W'(nvsc_pkg::RECALL_CYC) :
							nvsc_pkg::CNT_W'(STORE_CYC);
						state <= ST_NVWAIT;
					end else if (is_seq) begin
						// Next step only after one full gap; no foreign access between
						seq_idx <= seq_idx + 1'b1;
						sram_addr <= seq_addr(seq_idx + 1'b1, cmd == nvsc_pkg::CMD_SRECALL);
						chip_sel_n <= 1'b0;
						cnt <= nvsc_pkg::CNT_W'(nvsc_pkg::ACC_CYC - 1);
						state <= ST_ACC;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_PULSE: begin
					if (cnt_end) begin
						store_busy_n_oe <= 1'b0;
						cnt <= nvsc_pkg::CNT_W'(nvsc_pkg::BUSY_CYC);
						state <= ST_BWAIT;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				ST_BWAIT: begin
					// Give the device time to take the pin, then wait for release
					if (!cnt_end) begin
						cnt <= cnt - 1'b1;
					end else if (store_busy_n_i) begin
						cnt <= nvsc_pkg::CNT_W'(nvsc_pkg::RECOVER_CYC);
						state <= ST_RECOV;
					end
				end
				ST_RECOV: begin
					if (cnt_end) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				ST_NVWAIT: begin
					if (cnt_end) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	assign store_busy_n_o = 1'b0;
endmodule
